// File: verilog/ispfc_pkg.sv
package ispfc_pkg;

  // Register offsets on the special function register port.
  localparam logic [7:0] PROG_CONTROL_ADDR = 8'h9F;
  localparam logic [7:0] ROM_BANKING_ADDR = 8'hAB;
  localparam logic [7:0] PROG_ADDR_LOW_ADDR = 8'hAC;
  localparam logic [7:0] PROG_ADDR_HIGH_ADDR = 8'hAD;
  localparam logic [7:0] PROG_DATA_ADDR = 8'hAE;
  localparam logic [7:0] PROG_OPMODE_ADDR = 8'hAF;

  // Field positions in the programming control register.
  localparam int CTL_RESET_BIT = 7;
  localparam int CTL_EXEC_BIT = 5;
  localparam int CTL_LOADER_SELECT_BIT = 1;
  localparam int CTL_ENABLE_BIT = 0;

  // Field positions in the banking control register.
  localparam int BANK_EN_BIT = 3;

  // Values after reset.
  localparam logic [7:0] PROG_CONTROL_RST = 8'h00;
  localparam logic [3:0] ROM_BANKING_RST = 4'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OPMODE_RST = 8'h30;

  // Operation codes.
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;

  // Flash timing in cycles, and loader size in bytes.
  localparam int FLASH_READ_CYCLES = 2;
  localparam int FLASH_PROGRAM_CYCLES = 4;
  localparam int FLASH_ERASE_CYCLES = 16;
  localparam int LOADER_BYTES = 4096;

  // Operation mode register fields.
  typedef struct packed {
    logic bank;
    logic target_region_select;
    logic flash_output_enable_n;
    logic flash_chip_enable_n;
    logic [3:0] op_code;
  } ispfc_opmode_t;

  // Request that travels to the flash array model.
  typedef struct packed {
    logic [1:0] region;
    logic [15:0] addr;
    logic [7:0] data;
    logic [3:0] op_code;
  } ispfc_req_t;

  typedef enum logic [1:0] {
    REGION_AP0,
    REGION_AP1,
    REGION_LOADER
  } ispfc_region_t;

endpackage

// File: verilog/ispfc_bank_mux.sv
`timescale 1ns/10ps
`default_nettype none
module ispfc_bank_mux (
  // Banking settings.
  input wire logic banking_enable,
  input wire logic [2:0] pin_select,
  // Port 1 pin levels.
  input wire logic [7:0] port1_in,
  // Seventeenth address line.
  output logic a16
);

  logic [7:0] pick;

  // One term per port pin; only the selected pin reaches the address line.
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      assign pick[i] = (pin_select == 3'(i)) & port1_in[i];
    end
  endgenerate

  // Without banking only bank zero is reachable.
  assign a16 = banking_enable & (|pick);

endmodule
`default_nettype wire

// File: verilog/ispfc_flash_array.sv
`timescale 1ns/10ps
`default_nettype none
module ispfc_flash_array (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Operation request.
  input wire logic start,
  input wire ispfc_pkg::ispfc_req_t req,
  // Completion.
  output logic done,
  output logic [7:0] rdata
);

  // Storage for loader and both application banks.
  logic [7:0] loader_mem [0:ispfc_pkg::LOADER_BYTES-1];
  logic [7:0] app_mem [0:131071];
  logic [4:0] cnt_r;
  logic busy_r;
  logic [16:0] app_addr;

  assign app_addr = {req.region == ispfc_pkg::REGION_AP1, req.addr};

  // Busy counter models the array's operation time.
  // Reset is needed: an unknown busy flag would lock the array out for good.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      unique case (req.op_code)
        ispfc_pkg::OP_ERASE: cnt_r <= 5'(ispfc_pkg::FLASH_ERASE_CYCLES);
        ispfc_pkg::OP_PROGRAM: cnt_r <= 5'(ispfc_pkg::FLASH_PROGRAM_CYCLES);
        default: cnt_r <= 5'(ispfc_pkg::FLASH_READ_CYCLES);
      endcase
    end else if (busy_r) begin
      if (cnt_r == 5'h01) begin
        busy_r <= 1'b0;
        done <= 1'b1;
      end
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // Data path; erase wipes the whole region at once, the counter still models its time.
  always_ff @(posedge clk) begin
    if (start && !busy_r) begin
      if (req.op_code == ispfc_pkg::OP_ERASE) begin
        if (req.region == ispfc_pkg::REGION_LOADER) begin
          for (int j = 0; j < ispfc_pkg::LOADER_BYTES; j++) begin
            loader_mem[j] <= 8'hFF;
          end
        end else begin
          for (int j = 0; j < 65536; j++) begin
            app_mem[{req.region == ispfc_pkg::REGION_AP1, 16'(j)}] <= 8'hFF;
          end
        end
      end else if (req.op_code == ispfc_pkg::OP_PROGRAM) begin
        if (req.region == ispfc_pkg::REGION_LOADER) begin
          loader_mem[req.addr[11:0]] <= req.data;
        end else begin
          app_mem[app_addr] <= req.data;
        end
      end else if (req.op_code == ispfc_pkg::OP_READ) begin
        rdata <= (req.region == ispfc_pkg::REGION_LOADER) ? loader_mem[req.addr[11:0]] : app_mem[app_addr];
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/ispfc_top.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Top bit write resets whole device, self-clears.
// - Top bit reads high in reboot mode.
// - Read-only bit shows loader execution.
// - Loader select redirects fetches to loader.
// - Enable bit enters programming mode.
// - Idle request runs flash operation instead.
// - Clearing enable restores genuine idle.
// - Value 83h plus idle gives timed reset.
// - Two address bytes form flash address.
// - Data register carries program and read bytes.
// - Bank bit picks application bank.
// - Region bit picks application or loader.
// - Erase code clears whole region.
// - Program code writes data byte.
// - Read code returns byte in data.
// - Enable lines driven straight from bits.
// - Banking enable drives A16 from pin.
// - Pin-select field chooses pin, default seven.
module ispfc_top (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // CPU idle handshake.
  input wire logic IDLE_REQ,
  input wire logic TIMER_EXPIRED,
  output logic CPU_IDLE,
  output logic CPU_HOLD,
  // Boot and reset.
  input wire logic REBOOT_STRAP,
  output logic DEVICE_RESET,
  output logic FETCH_LOADER,
  // Flash control lines and banking.
  output logic FLASH_OE_N,
  output logic FLASH_CE_N,
  input wire logic [7:0] PORT1_IN,
  output logic A16
);

  typedef enum {
    ST_RUN,
    ST_OP,
    ST_IDLE,
    ST_TIMED
  } ispfc_state_t;

  ispfc_state_t state_r;
  logic soft_reset_reboot_flag_r;
  logic reboot_mode_r;
  logic executing_region_status_r;
  logic loader_select_r;
  logic programming_enable_r;
  logic [3:0] rom_banking_control_r;
  logic [7:0] prog_address_low_r;
  logic [7:0] prog_address_high_r;
  logic [7:0] prog_data_buffer_r;
  ispfc_pkg::ispfc_opmode_t prog_operation_mode_r;
  ispfc_pkg::ispfc_req_t req;
  logic op_start;
  logic op_done;
  logic [7:0] op_rdata;
  logic a16_nxt;
  logic [7:0] rdata_nxt;
  logic reset_req_nxt;

  // The strap is caught by a clocked process so reset only loads constants.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      reboot_mode_r <= 1'b0;
    end else begin
      reboot_mode_r <= REBOOT_STRAP;
    end
  end

  // Programming control bits.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      soft_reset_reboot_flag_r <= 1'b0;
      loader_select_r <= 1'b0;
      programming_enable_r <= 1'b0;
    end else if (WR && ADDR == ispfc_pkg::PROG_CONTROL_ADDR) begin
      soft_reset_reboot_flag_r <= WDATA[ispfc_pkg::CTL_RESET_BIT];
      loader_select_r <= WDATA[ispfc_pkg::CTL_LOADER_SELECT_BIT];
      programming_enable_r <= WDATA[ispfc_pkg::CTL_ENABLE_BIT];
    end else if (DEVICE_RESET) begin
      // The request bit clears itself once the reset pulse has gone out.
      soft_reset_reboot_flag_r <= 1'b0;
    end
  end

  // A self-reset request fires now unless it is armed for the timer.
  always_comb begin
    reset_req_nxt = 1'b0;
    if (soft_reset_reboot_flag_r && !programming_enable_r && !DEVICE_RESET) begin
      reset_req_nxt = 1'b1;
    end
    if (state_r == ST_TIMED && TIMER_EXPIRED && !DEVICE_RESET) begin
      reset_req_nxt = 1'b1;
    end
  end

  // Device reset pulse; the flag above is cleared by that same reset.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      DEVICE_RESET <= 1'b0;
    end else begin
      DEVICE_RESET <= reset_req_nxt;
    end
  end

  // Executing region follows the loader select, one register stage behind the fetch line.
  // Restarting from application flash after the timed reset falls out of this.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      executing_region_status_r <= 1'b0;
      FETCH_LOADER <= 1'b0;
    end else begin
      FETCH_LOADER <= loader_select_r;
      executing_region_status_r <= FETCH_LOADER;
    end
  end

  // Banking and address registers.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rom_banking_control_r <= ispfc_pkg::ROM_BANKING_RST;
      prog_address_low_r <= ispfc_pkg::BYTE_RST;
      prog_address_high_r <= ispfc_pkg::BYTE_RST;
    end else if (WR) begin
      if (ADDR == ispfc_pkg::ROM_BANKING_ADDR) begin
        rom_banking_control_r <= WDATA[3:0];
      end
      if (ADDR == ispfc_pkg::PROG_ADDR_LOW_ADDR) begin
        prog_address_low_r <= WDATA;
      end
      if (ADDR == ispfc_pkg::PROG_ADDR_HIGH_ADDR) begin
        prog_address_high_r <= WDATA;
      end
    end
  end

  // Data buffer; a read result lands here when the array finishes.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      prog_data_buffer_r <= ispfc_pkg::BYTE_RST;
    end else if (op_done && req.op_code == ispfc_pkg::OP_READ) begin
      prog_data_buffer_r <= op_rdata;
    end else if (WR && ADDR == ispfc_pkg::PROG_DATA_ADDR) begin
      prog_data_buffer_r <= WDATA;
    end
  end

  // Operation mode register.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      prog_operation_mode_r <= ispfc_pkg::OPMODE_RST;
    end else if (WR && ADDR == ispfc_pkg::PROG_OPMODE_ADDR) begin
      prog_operation_mode_r <= WDATA;
    end
  end

  // Flash enable lines come straight from software bits.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FLASH_OE_N <= 1'b1;
      FLASH_CE_N <= 1'b1;
    end else begin
      FLASH_OE_N <= prog_operation_mode_r.flash_output_enable_n;
      FLASH_CE_N <= prog_operation_mode_r.flash_chip_enable_n;
    end
  end

  // Request assembly from the address, data and mode registers.
  always_comb begin
    req.addr = {prog_address_high_r, prog_address_low_r};
    req.data = prog_data_buffer_r;
    req.op_code = prog_operation_mode_r.op_code;
    if (prog_operation_mode_r.target_region_select) begin
      req.region = 2'(ispfc_pkg::REGION_LOADER);
    end else if (prog_operation_mode_r.bank) begin
      req.region = 2'(ispfc_pkg::REGION_AP1);
    end else begin
      req.region = 2'(ispfc_pkg::REGION_AP0);
    end
  end

  // An operation is accepted only with a legal enable pattern for its code.
  always_comb begin
    op_start = 1'b0;
    if (state_r == ST_RUN && IDLE_REQ && programming_enable_r && !soft_reset_reboot_flag_r
        && !prog_operation_mode_r.flash_chip_enable_n) begin
      unique case (req.op_code)
        ispfc_pkg::OP_ERASE: op_start = prog_operation_mode_r.flash_output_enable_n;
        ispfc_pkg::OP_PROGRAM: op_start = prog_operation_mode_r.flash_output_enable_n;
        ispfc_pkg::OP_READ: op_start = !prog_operation_mode_r.flash_output_enable_n;
        default: op_start = 1'b0;
      endcase
    end
  end

  // Idle sequencing: operation, genuine idle, or armed timed reset.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= ST_RUN;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (IDLE_REQ) begin
            if (programming_enable_r && soft_reset_reboot_flag_r) begin
              state_r <= ST_TIMED;
            end else if (op_start) begin
              state_r <= ST_OP;
            end else if (!programming_enable_r) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_OP: begin
          if (op_done) begin
            state_r <= ST_RUN;
          end
        end
        ST_IDLE: begin
          if (!IDLE_REQ) begin
            state_r <= ST_RUN;
          end
        end
        ST_TIMED: begin
          state_r <= ST_TIMED;
        end
      endcase
    end
  end

  // CPU sees a hold during operations and true idle in genuine idle or an armed timed reset.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      CPU_HOLD <= 1'b0;
      CPU_IDLE <= 1'b0;
    end else begin
      CPU_HOLD <= (state_r == ST_OP && !op_done) || op_start;
      CPU_IDLE <= (state_r == ST_IDLE) || (state_r == ST_TIMED);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (ADDR)
      ispfc_pkg::PROG_CONTROL_ADDR: begin
        rdata_nxt[ispfc_pkg::CTL_RESET_BIT] = reboot_mode_r;
        rdata_nxt[ispfc_pkg::CTL_EXEC_BIT] = executing_region_status_r;
        rdata_nxt[ispfc_pkg::CTL_LOADER_SELECT_BIT] = loader_select_r;
        rdata_nxt[ispfc_pkg::CTL_ENABLE_BIT] = programming_enable_r;
      end
      ispfc_pkg::ROM_BANKING_ADDR: rdata_nxt = {4'h0, rom_banking_control_r};
      ispfc_pkg::PROG_ADDR_LOW_ADDR: rdata_nxt = prog_address_low_r;
      ispfc_pkg::PROG_ADDR_HIGH_ADDR: rdata_nxt = prog_address_high_r;
      ispfc_pkg::PROG_DATA_ADDR: rdata_nxt = prog_data_buffer_r;
      ispfc_pkg::PROG_OPMODE_ADDR: rdata_nxt = prog_operation_mode_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Banking address line, registered for a clean output.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      A16 <= 1'b0;
    end else begin
      A16 <= a16_nxt;
    end
  end

  ispfc_bank_mux u_bank (
    .banking_enable(rom_banking_control_r[ispfc_pkg::BANK_EN_BIT]),
    .pin_select(rom_banking_control_r[2:0]),
    .port1_in(PORT1_IN),
    .a16(a16_nxt)
  );

  ispfc_flash_array u_flash (
    .clk(MCLK),
    .rst(RESET),
    .start(op_start),
    .req(req),
    .done(op_done),
    .rdata(op_rdata)
  );

endmodule
`default_nettype wire

// File: sim/ispfc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ispfc_chk (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Idle handshake and boot.
  input wire logic IDLE_REQ,
  input wire logic CPU_IDLE,
  input wire logic CPU_HOLD,
  input wire logic REBOOT_STRAP,
  input wire logic DEVICE_RESET,
  input wire logic FETCH_LOADER,
  // Flash lines and banking.
  input wire logic FLASH_OE_N,
  input wire logic FLASH_CE_N,
  input wire logic [7:0] PORT1_IN,
  input wire logic A16
);
  // One clock domain, so every check is quiet while RESET is high.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  a_reset_one_cycle: assert property (DEVICE_RESET |=> !DEVICE_RESET)
    else $error("device reset pulse too long");
  a_soft_reset_now: assert property (WR && ADDR == 8'h9F && WDATA == 8'h80 |-> ##[1:2] DEVICE_RESET)
    else $error("no device reset after control write");
  a_reboot_read: assert property (RD && ADDR == 8'h9F |=> RDATA[7] == $past(REBOOT_STRAP, 2))
    else $error("reboot flag not read back");
  a_hold_from_idle: assert property ($rose(CPU_HOLD) |-> $past(IDLE_REQ))
    else $error("hold without idle request");
  a_hold_not_idle: assert property (CPU_HOLD |-> !CPU_IDLE)
    else $error("true idle during flash operation");
  a_hold_ends: assert property ($rose(CPU_HOLD) |-> ##[2:40] !CPU_HOLD)
    else $error("CPU never resumed");
  // The strobe lines are copies of the register, so they follow two cycles after a quiet write.
  a_enable_lines: assert property (WR && ADDR == 8'hAF && WDATA[5:4] == 2'h2 ##1 !(WR && ADDR == 8'hAF) [*2]
    |-> FLASH_OE_N && !FLASH_CE_N)
    else $error("flash enables not from register");
  a_loader_fetch: assert property (WR && ADDR == 8'h9F && WDATA == 8'h02 |-> ##[1:2] FETCH_LOADER)
    else $error("loader select ignored");
  a_a16_low: assert property (PORT1_IN == 8'h00 |=> !A16)
    else $error("A16 high with port pins low");

  // Main scenarios reached.
  c_flash_op: cover property (CPU_HOLD ##1 !CPU_HOLD);
  c_timed_reset: cover property (CPU_IDLE ##[1:3] DEVICE_RESET);
  c_bank_line: cover property (A16);
endmodule
bind ispfc_top ispfc_chk u_chk (.*);
`default_nettype wire

// File: sim/ispfc_timer_model.sv
`timescale 1ns/10ps
`default_nettype none
module ispfc_timer_model #(parameter int TICKS = 20) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Counting gate and time-out.
  input wire logic run,
  output logic expired
);
  logic [7:0] count_r;
  // The timer only runs while the CPU waits, so it can never end a wait early.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_r <= 8'h00;
      expired <= 1'h0;
    end else begin
      count_r <= count_r + 8'h01;
      expired <= (count_r == 8'(TICKS));
    end
  end
endmodule
`default_nettype wire

// File: sim/test_isp_flash_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_isp_flash_control;
  logic mclk;
  logic reset = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic idle_req = 1'h0;
  logic strap = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] port1 = 8'h00;
  logic [7:0] rdata;
  logic timer_expired, cpu_idle, cpu_hold, dev_reset, fetch_loader, oe_n, ce_n, a16;
  int failures = 0;
  int checked = 0;

  // Device under test and the idle timer it waits on.
  ispfc_top u_ispfc_top (.MCLK(mclk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IDLE_REQ(idle_req), .TIMER_EXPIRED(timer_expired), .CPU_IDLE(cpu_idle),
    .CPU_HOLD(cpu_hold), .REBOOT_STRAP(strap), .DEVICE_RESET(dev_reset), .FETCH_LOADER(fetch_loader),
    .FLASH_OE_N(oe_n), .FLASH_CE_N(ce_n), .PORT1_IN(port1), .A16(a16));
  ispfc_timer_model u_ispfc_timer_model (.clk(mclk), .rst(reset), .run(cpu_idle), .expired(timer_expired));

  // Clock at 100 MHz.
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Shared helpers.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reset_dut();
    reset <= 1'h1;
    idle_req <= 1'h0;
    repeat (8) @(posedge mclk);
    reset <= 1'h0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled mid-cycle there.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input bit same = 1'b1);
    @(posedge mclk);
    rd <= 1'h1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'h0;
    @(negedge mclk);
    checked++;
    if ((rdata === exp) != same) begin
      failures++;
      $display("BAD %0t read %h got %h", $time, a, rdata);
    end
  endtask
  // Idle is requested until the hold shows the operation has started.
  task automatic flash_op(input logic [7:0] mode);
    int n;
    wr_reg(8'hAF, mode);
    @(posedge mclk);
    idle_req <= 1'h1;
    for (n = 0; n < 20 && cpu_hold !== 1'h1; n++) @(negedge mclk);
    chk({7'h00, cpu_hold}, 8'h01);
    chk({6'h00, oe_n, ce_n}, {6'h00, mode[5:4]});
    @(posedge mclk);
    idle_req <= 1'h0;
    for (n = 0; n < 60 && cpu_hold !== 1'h0; n++) @(negedge mclk);
    chk({7'h00, cpu_hold}, 8'h00);
  endtask

  // Scenarios.
  task automatic t_reset_vals();
    logic [7:0] regs [6] = '{8'h9F, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
    logic [7:0] vals [6] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h30};
    for (int i = 0; i < 6; i++) rd_reg(regs[i], vals[i]);
    rd_reg(8'h90, 8'h00);
    chk({6'h00, oe_n, ce_n}, 8'h03);
  endtask
  task automatic t_control();
    @(posedge mclk);
    strap <= 1'h1;
    rd_reg(8'h9F, 8'h80);
    @(posedge mclk);
    strap <= 1'h0;
    wr_reg(8'h9F, 8'h20);
    rd_reg(8'h9F, 8'h00);
    wr_reg(8'h9F, 8'h02);
    repeat (3) @(negedge mclk);
    chk({7'h00, fetch_loader}, 8'h01);
    rd_reg(8'h9F, 8'h22);
    wr_reg(8'h9F, 8'h00);
    repeat (3) @(posedge mclk);
    rd_reg(8'h9F, 8'h00);
  endtask
  task automatic t_flash();
    logic [7:0] base [3] = '{8'h00, 8'h80, 8'h40};
    wr_reg(8'h9F, 8'h01);
    wr_reg(8'hAD, 8'h12);
    wr_reg(8'hAC, 8'h34);
    rd_reg(8'hAD, 8'h12);
    for (int k = 0; k < 3; k++) begin
      flash_op(base[k] | 8'h22);
      wr_reg(8'hAE, 8'hA0 + 8'(k));
      flash_op(base[k] | 8'h21);
    end
    for (int k = 0; k < 3; k++) begin
      wr_reg(8'hAE, 8'h00);
      flash_op(base[k]);
      rd_reg(8'hAE, 8'hA0 + 8'(k));
    end
    // Erase ignores the address, so a byte elsewhere in the bank is lost too.
    wr_reg(8'hAC, 8'h00);
    flash_op(8'h22);
    wr_reg(8'hAC, 8'h34);
    flash_op(8'h00);
    rd_reg(8'hAE, 8'hA0, 1'b0);
    flash_op(8'h80);
    rd_reg(8'hAE, 8'hA1);
  endtask
  task automatic t_banking();
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'hAB, 8'h08 | 8'(s));
      port1 <= 8'h01 << s;
      repeat (3) @(negedge mclk);
      chk({7'h00, a16}, 8'h01);
      @(posedge mclk);
      port1 <= ~(8'h01 << s);
      repeat (3) @(negedge mclk);
      chk({7'h00, a16}, 8'h00);
    end
    wr_reg(8'hAB, 8'h07);
    port1 <= 8'hFF;
    repeat (3) @(negedge mclk);
    chk({7'h00, a16}, 8'h00);
    rd_reg(8'hAB, 8'h07);
    port1 <= 8'h00;
  endtask
  task automatic t_idle();
    wr_reg(8'h9F, 8'h00);
    @(posedge mclk);
    idle_req <= 1'h1;
    repeat (3) @(negedge mclk);
    chk({6'h00, cpu_idle, cpu_hold}, 8'h02);
  endtask
  task automatic t_swreset();
    int n;
    wr_reg(8'h9F, 8'h80);
    for (n = 0; n < 5 && dev_reset !== 1'h1; n++) @(negedge mclk);
    chk({7'h00, dev_reset}, 8'h01);
    reset_dut();
    rd_reg(8'h9F, 8'h00);
    wr_reg(8'h9F, 8'h83);
    @(posedge mclk);
    idle_req <= 1'h1;
    for (n = 0; n < 10 && cpu_idle !== 1'h1; n++) @(negedge mclk);
    chk({6'h00, cpu_idle, dev_reset}, 8'h02);
    for (n = 0; n < 60 && dev_reset !== 1'h1; n++) @(negedge mclk);
    chk({7'h00, dev_reset}, 8'h01);
    reset_dut();
    chk({7'h00, fetch_loader}, 8'h00);
  endtask

  // Main sequence.
  initial begin
    reset_dut();
    t_reset_vals();
    t_control();
    t_flash();
    t_banking();
    t_idle();
    t_swreset();
    finish_test();
  end

  // The sequence needs under two thousand cycles; this bound only cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
